// file: src/swurc_consts.vh
// swurc_consts.vh: constants for the single wire uart read/crc slave
// assumes a 25 MHz system clock and a host uart framing 8N1
`ifndef SWURC_CONSTS_VH
`define SWURC_CONSTS_VH

// datagram layout
`define SWURC_RW_BIT 3'h7
`define SWURC_LAST_RD 3'h3
`define SWURC_LAST_WR 3'h7
`define SWURC_REPLY_SYNC 8'h05
`define SWURC_REPLY_ADDR 8'hFF
// receive state right after the sync measurement (bits 0..2 known)
`define SWURC_SYNC_BYTE 8'hA0
`define SWURC_SYNC_CRC 8'h07
`define SWURC_SYNC_SLOT 4'h4
`define SWURC_STOP_SLOT 4'h9
// timing, in bit times or clock cycles
`define SWURC_GLITCH_CYC 22'h00_0010
`define SWURC_MIN_BT 16'h0010
`define SWURC_RESET_BT 16'h0010
`define SWURC_SYNC_MAX 22'h00_4000
`define SWURC_GAP_BITS 22'h00_003F
`define SWURC_IDLE_BITS 22'h00_000C
`define SWURC_HOLD_BITS 8'h04
`define SWURC_DELAY_BASE 8'h09

`endif

// file: src/swurc_crc8.v
// swurc_crc8.v: one serial step of the datagram crc
// assumes the caller holds the crc register and feeds one bit per step
`timescale 1ns/10ps

module swurc_crc8 (
  // running value and incoming bit
  input wire [7:0] crc_i,
  input wire bit_i,
  // updated value
  output wire [7:0] crc_o
);

  // serial crc step
  // shift left, new low bit from taps 7, 1, 0 and the data bit
  assign crc_o = {crc_i[6:0], crc_i[7] ^ crc_i[1] ^ crc_i[0] ^ bit_i};

endmodule

// file: src/swurc_buf2.v
// swurc_buf2.v: two-entry valid/ready buffer, all outputs registered
// assumes source and sink share the clock and the synchronous reset
`timescale 1ns/10ps

module swurc_buf2 #(
  parameter W = 39
) (
  // clock and reset
  input wire clk_i,
  input wire rstn_i,
  // filling side
  input wire in_valid_i,
  input wire [W-1:0] in_data_i,
  output reg in_ready_o,
  // draining side
  output reg out_valid_o,
  output reg [W-1:0] out_data_o,
  input wire out_ready_i
);

  reg skid_valid;
  reg [W-1:0] skid_data;
  wire push;
  wire pop;

  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  // head register plus skid entry; ready drops when both hold data
  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      out_valid_o <= 1'b0;
      out_data_o <= {W{1'b0}};
      skid_valid <= 1'b0;
      skid_data <= {W{1'b0}};
      in_ready_o <= 1'b1;
    end
    else
    begin
      if (!out_valid_o || pop)
      begin
        if (skid_valid)
        begin
          out_valid_o <= 1'b1;
          out_data_o <= skid_data;
          skid_valid <= push;
          skid_data <= in_data_i;
          in_ready_o <= !push;
        end
        else
        begin
          out_valid_o <= push;
          if (push)
            out_data_o <= in_data_i;
          in_ready_o <= 1'b1;
        end
      end
      else if (push)
      begin
        skid_valid <= 1'b1;
        skid_data <= in_data_i;
        in_ready_o <= 1'b0;
      end
    end
  end

endmodule

// file: src/swurc_top.v
// swurc_top.v: single wire uart slave, read reply with crc
// assumes a host uart mastering the shared line and a register file
// outside that answers a read address on RD_DATA_I within the delay
`timescale 1ns/10ps
`include "swurc_consts.vh"

module swurc_top (
  // clock and reset
  input wire CLK_I,
  input wire RSTN_I,
  // shared serial pin, split
  input wire SHARED_SERIAL_LINE_I,
  output reg SHARED_SERIAL_LINE_O,
  output reg SHARED_SERIAL_LINE_OE_O,
  // address straps and reply delay
  input wire ADDR_SELECT_BIT0_I,
  input wire ADDR_SELECT_BIT1_I,
  input wire [3:0] REPLY_DELAY_SETTING_I,
  // read request to the register file
  output reg RD_REQ_O,
  output reg [6:0] RD_ADDR_O,
  input wire [31:0] RD_DATA_I,
  // accepted write datagrams
  output wire WR_VALID_O,
  output wire [6:0] WR_ADDR_O,
  output wire [31:0] WR_DATA_O,
  input wire WR_READY_I,
  // datagram counter
  output reg [7:0] DGRAM_CNT_O
);

  // one-hot states
  localparam [7:0] ST_ERRW = 8'h01;
  localparam [7:0] ST_IDLE = 8'h02;
  localparam [7:0] ST_SYNC = 8'h04;
  localparam [7:0] ST_BITS = 8'h08;
  localparam [7:0] ST_GAP = 8'h10;
  localparam [7:0] ST_TDLY = 8'h20;
  localparam [7:0] ST_TX = 8'h40;
  localparam [7:0] ST_HOLD = 8'h80;

  reg [7:0] state;
  reg [2:0] line_sync;
  reg line_f;
  reg line_prev;
  reg [2:0] a0_sync;
  reg [2:0] a1_sync;
  reg [1:0] node_address;
  reg [15:0] bt;
  reg [15:0] ph;
  reg [21:0] cnt;
  reg fe_seen;
  reg [3:0] bitn;
  reg [2:0] byten;
  reg [7:0] rxb;
  reg [7:0] crc;
  reg [7:0] crc_st;
  reg is_wr;
  reg addr_ok;
  reg [31:0] wdata;
  reg [7:0] dcnt;
  reg [55:0] txsh;
  reg push;
  reg [38:0] push_data;
  reg was_errw;

  wire fall;
  wire rise;
  wire tick;
  wire [21:0] bt22;
  wire [21:0] gap_lim;
  wire [21:0] idle_lim;
  wire crc_bit;
  wire [7:0] next_crc;
  wire buf_ready;
  wire last_byte;
  wire [21:0] sync_len;

  assign fall = line_prev & ~line_f;
  assign rise = ~line_prev & line_f;
  assign tick = (ph == bt - 16'h0001);
  assign bt22 = {6'h00, bt};
  assign gap_lim = bt22 * `SWURC_GAP_BITS;
  assign idle_lim = bt22 * `SWURC_IDLE_BITS;
  // cycles from start edge, counting the detect cycle itself
  assign sync_len = cnt + 22'h00_0001;
  assign last_byte = (byten == `SWURC_LAST_RD && !is_wr) || byten == `SWURC_LAST_WR;

  assign crc_bit = (state == ST_TX) ? txsh[0] : line_f;

  // shared serial crc step for receive and transmit
  swurc_crc8 u_crc (
    .crc_i(crc),
    .bit_i(crc_bit),
    .crc_o(next_crc)
  );

  // write datagram queue toward the register file
  swurc_buf2 #(
    .W(39)
  ) u_buf (
    .clk_i(CLK_I),
    .rstn_i(RSTN_I),
    .in_valid_i(push),
    .in_data_i(push_data),
    .in_ready_o(buf_ready),
    .out_valid_o(WR_VALID_O),
    .out_data_o({WR_ADDR_O, WR_DATA_O}),
    .out_ready_i(WR_READY_I)
  );

  // pin synchronisers: a level counts once stages two and three agree
  always @(posedge CLK_I)
  begin
    if (!RSTN_I)
    begin
      line_sync <= 3'h7;
      line_f <= 1'b1;
      line_prev <= 1'b1;
      a0_sync <= 3'h0;
      a1_sync <= 3'h0;
      node_address <= 2'h0;
    end
    else
    begin
      line_sync <= {line_sync[1:0], SHARED_SERIAL_LINE_I};
      a0_sync <= {a0_sync[1:0], ADDR_SELECT_BIT0_I};
      a1_sync <= {a1_sync[1:0], ADDR_SELECT_BIT1_I};
      line_prev <= line_f;
      if (line_sync[1] == line_sync[2])
        line_f <= line_sync[2];
      if (a0_sync[1] == a0_sync[2])
        node_address[0] <= a0_sync[2];
      if (a1_sync[1] == a1_sync[2])
        node_address[1] <= a1_sync[2];
    end
  end

  // receive, reply delay and transmit sequencer
  always @(posedge CLK_I)
  begin
    if (!RSTN_I)
    begin
      state <= ST_ERRW;
      bt <= `SWURC_RESET_BT;
      ph <= 16'h0000;
      cnt <= 22'h00_0000;
      fe_seen <= 1'b0;
      bitn <= 4'h0;
      byten <= 3'h0;
      rxb <= 8'h00;
      crc <= 8'h00;
      crc_st <= 8'h00;
      is_wr <= 1'b0;
      addr_ok <= 1'b0;
      wdata <= 32'h0000_0000;
      dcnt <= 8'h00;
      txsh <= 56'h0;
      push <= 1'b0;
      push_data <= 39'h0;
      was_errw <= 1'b0;
      RD_REQ_O <= 1'b0;
      RD_ADDR_O <= 7'h00;
      DGRAM_CNT_O <= 8'h00;
      SHARED_SERIAL_LINE_O <= 1'b1;
      SHARED_SERIAL_LINE_OE_O <= 1'b0;
    end
    else
    begin
      push <= 1'b0;
      RD_REQ_O <= 1'b0;
      was_errw <= (state == ST_ERRW);
      // bit phase runs in every timed state
      ph <= tick ? 16'h0000 : ph + 16'h0001;
      case (state)
        ST_ERRW:
        begin
          // idle count restarts on entry and whenever the line drops
          cnt <= (line_f && was_errw) ? cnt + 22'h00_0001 : 22'h00_0000;
          if (line_f && was_errw && cnt >= idle_lim)
            state <= ST_IDLE;
        end
        ST_IDLE:
        begin
          cnt <= 22'h00_0000;
          fe_seen <= 1'b0;
          if (fall)
            state <= ST_SYNC;
        end
        ST_SYNC:
        begin
          cnt <= cnt + 22'h00_0001;
          if (rise && sync_len < `SWURC_GLITCH_CYC)
            state <= ST_ERRW;
          else if (cnt >= `SWURC_SYNC_MAX)
            state <= ST_ERRW;
          else if (fall && !fe_seen)
            fe_seen <= 1'b1;
          else if (fall)
          begin
            // start edge to sync bit 3 edge spans four bit times
            bt <= sync_len[17:2];
            if (sync_len[17:2] < `SWURC_MIN_BT)
              state <= ST_ERRW;
            else
            begin
              ph <= {1'b0, sync_len[17:3]};
              bitn <= `SWURC_SYNC_SLOT;
              byten <= 3'h0;
              rxb <= `SWURC_SYNC_BYTE;
              crc <= `SWURC_SYNC_CRC;
              is_wr <= 1'b0;
              addr_ok <= 1'b0;
              state <= ST_BITS;
            end
          end
        end
        // sample each slot mid-bit; cnt keeps timing from the start edge
        ST_BITS:
        begin
          cnt <= cnt + 22'h00_0001;
          if (tick)
          begin
            if (bitn == 4'h0)
            begin
              crc_st <= crc;
              bitn <= 4'h1;
              if (line_f)
                state <= ST_ERRW;
            end
            else if (bitn != `SWURC_STOP_SLOT)
            begin
              rxb <= {line_f, rxb[7:1]};
              crc <= next_crc;
              bitn <= bitn + 4'h1;
            end
            else if (!line_f)
              state <= ST_ERRW;
            else
            begin
              if (byten == 3'h1)
                addr_ok <= (rxb == {6'h00, node_address});
              if (byten == 3'h2)
              begin
                is_wr <= rxb[`SWURC_RW_BIT];
                RD_ADDR_O <= rxb[6:0];
              end
              if (is_wr && byten >= 3'h3)
                wdata <= {wdata[23:0], rxb};
              if (!last_byte)
              begin
                byten <= byten + 3'h1;
                state <= ST_GAP;
              end
              else if (rxb != crc_st)
                state <= ST_ERRW;
              else if (!addr_ok)
                state <= ST_IDLE;
              else if (is_wr)
              begin
                push <= buf_ready;
                push_data <= {RD_ADDR_O, wdata};
                if (buf_ready)
                  DGRAM_CNT_O <= DGRAM_CNT_O + 8'h01;
                state <= ST_IDLE;
              end
              else
              begin
                RD_REQ_O <= 1'b1;
                ph <= {1'b0, bt[15:1]};
                dcnt <= {1'b0, REPLY_DELAY_SETTING_I, 3'h0} + `SWURC_DELAY_BASE;
                state <= ST_TDLY;
              end
            end
          end
        end
        ST_GAP:
        begin
          cnt <= cnt + 22'h00_0001;
          if (cnt > gap_lim)
            state <= ST_ERRW;
          else if (fall)
          begin
            cnt <= 22'h00_0000;
            ph <= {1'b0, bt[15:1]};
            bitn <= 4'h0;
            state <= ST_BITS;
          end
        end
        // reply delay, then load the reply frame
        ST_TDLY:
        begin
          if (tick)
          begin
            dcnt <= dcnt - 8'h01;
            if (dcnt == 8'h01)
            begin
              txsh <= {RD_DATA_I[7:0], RD_DATA_I[15:8], RD_DATA_I[23:16],
                RD_DATA_I[31:24], 1'b0, RD_ADDR_O, `SWURC_REPLY_ADDR, `SWURC_REPLY_SYNC};
              crc <= 8'h00;
              bitn <= 4'h0;
              byten <= 3'h0;
              SHARED_SERIAL_LINE_OE_O <= 1'b1;
              SHARED_SERIAL_LINE_O <= 1'b0;
              state <= ST_TX;
            end
          end
        end
        ST_TX:
        begin
          if (tick)
          begin
            bitn <= bitn + 4'h1;
            if (bitn < 4'h8)
            begin
              SHARED_SERIAL_LINE_O <= txsh[0];
              txsh <= {1'b0, txsh[55:1]};
              crc <= next_crc;
            end
            else if (bitn == 4'h8)
              SHARED_SERIAL_LINE_O <= 1'b1;
            else if (byten == `SWURC_LAST_WR)
            begin
              dcnt <= `SWURC_HOLD_BITS;
              state <= ST_HOLD;
            end
            else
            begin
              bitn <= 4'h0;
              byten <= byten + 3'h1;
              SHARED_SERIAL_LINE_O <= 1'b0;
              if (byten == 3'h6)
                txsh <= {48'h0, crc};
            end
          end
        end
        ST_HOLD:
        begin
          if (tick)
          begin
            dcnt <= dcnt - 8'h01;
            if (dcnt == 8'h01)
            begin
              SHARED_SERIAL_LINE_OE_O <= 1'b0;
              SHARED_SERIAL_LINE_O <= 1'b1;
              state <= ST_IDLE;
            end
          end
        end
        default:
          state <= ST_ERRW;
      endcase
    end
  end

endmodule

// file: tb/swurc_monitor.sv
// swurc_monitor.sv: port assertions for the uart read/crc slave
// assumes it is bound onto swurc_top; one clock, sync reset
`timescale 1ns/10ps

module swurc_monitor (
  // clock and reset
  input wire CLK_I,
  input wire RSTN_I,
  // serial pin and read strobe
  input wire SHARED_SERIAL_LINE_O,
  input wire SHARED_SERIAL_LINE_OE_O,
  input wire RD_REQ_O,
  // write sink and counter
  input wire WR_VALID_O,
  input wire [6:0] WR_ADDR_O,
  input wire [31:0] WR_DATA_O,
  input wire WR_READY_I,
  input wire [7:0] DGRAM_CNT_O
);
  reg [15:0] oe_len;
  reg [15:0] hi_run;
  reg armed;
  wire oe = SHARED_SERIAL_LINE_OE_O;
  wire tx = SHARED_SERIAL_LINE_O;
  default clocking mon_cb @(posedge CLK_I);
  endclocking
  default disable iff (!RSTN_I);
  // drive length, high tail length, read pending
  always @(posedge CLK_I)
  begin
    if (!RSTN_I)
    begin
      oe_len <= 16'h0000;
      hi_run <= 16'h0000;
      armed <= 1'b0;
    end
    else
    begin
      oe_len <= oe ? oe_len + 16'h0001 : 16'h0000;
      hi_run <= (oe && tx) ? hi_run + 16'h0001 : 16'h0000;
      armed <= RD_REQ_O | (armed & ~oe);
    end
  end
  a_idle_line_high: assert property (!oe |-> tx)
    else $error("line low while not driven");
  a_cnt_step_one: assert property (
    $changed(DGRAM_CNT_O) |-> DGRAM_CNT_O == $past(DGRAM_CNT_O) + 8'h01)
    else $error("counter moved by other than one");
  a_wr_head_hold: assert property (
    WR_VALID_O && !WR_READY_I |=> WR_VALID_O && $stable({WR_ADDR_O, WR_DATA_O}))
    else $error("write head changed while stalled");
  a_req_one_cycle: assert property (RD_REQ_O |=> !RD_REQ_O)
    else $error("read strobe longer than a cycle");
  a_req_not_driving: assert property (RD_REQ_O |-> !oe)
    else $error("read accepted while driving");
  a_reply_start_low: assert property ($rose(oe) |-> !tx)
    else $error("reply does not open with a start bit");
  a_drive_after_req: assert property ($rose(oe) |-> armed)
    else $error("driver on without a read");
  a_release_tail: assert property (
    $fell(oe) |-> hi_run >= 16'h0040 && oe_len >= 16'h0540)
    else $error("driver released too early");
  c_read: cover property (RD_REQ_O);
  c_reply_end: cover property ($fell(oe));
  c_write_count: cover property ($changed(DGRAM_CNT_O));
  c_sink_stall: cover property (WR_VALID_O && !WR_READY_I);
endmodule

bind swurc_top swurc_monitor u_mon (
  .CLK_I(CLK_I), .RSTN_I(RSTN_I), .SHARED_SERIAL_LINE_O(SHARED_SERIAL_LINE_O),
  .SHARED_SERIAL_LINE_OE_O(SHARED_SERIAL_LINE_OE_O), .RD_REQ_O(RD_REQ_O),
  .WR_VALID_O(WR_VALID_O), .WR_ADDR_O(WR_ADDR_O), .WR_DATA_O(WR_DATA_O),
  .WR_READY_I(WR_READY_I), .DGRAM_CNT_O(DGRAM_CNT_O)
);

// file: tb/swurc_host.sv
// swurc_host.sv: host uart on the shared wire, send and receive
// assumes the bench resolves the wire and calls tasks after an edge
`timescale 1ns/10ps

module swurc_host (
  // clock and resolved wire
  input wire clk_i,
  input wire line_i,
  // host transmit, high when released
  output reg tx_o
);
  initial tx_o = 1'b1;
  task send(input [7:0] b, input integer bt);
    integer j;
    begin
      for (j = 0; j < 10; j = j + 1)
      begin
        tx_o <= (j == 0) ? 1'b0 : (j == 9) ? 1'b1 : b[j-1];
        repeat (bt) @(posedge clk_i);
      end
    end
  endtask
  // only after own bytes, echo skipped
  task recv(input integer bt, output [7:0] b, output ok, output integer n);
    integer j;
    begin
      n = 0;
      while (line_i !== 1'b0 && n < 200 * bt)
      begin
        @(negedge clk_i);
        n = n + 1;
      end
      repeat (bt / 2) @(negedge clk_i);
      ok = (line_i === 1'b0);
      for (j = 0; j < 8; j = j + 1)
      begin
        repeat (bt) @(negedge clk_i);
        b[j] = line_i;
      end
      repeat (bt) @(negedge clk_i);
      ok = ok && (line_i === 1'b1);
    end
  endtask
endmodule

// file: tb/tb.sv
// tb.sv: self-checking bench for swurc_top with a host uart model
// assumes the host drives the wire whenever the device does not
`timescale 1ns/10ps

module tb;
  reg clk = 1'b0;
  reg rstn = 1'b0;
  reg s0 = 1'b0;
  reg s1 = 1'b0;
  reg wrdy = 1'b0;
  reg oe_q = 1'b0;
  reg ok;
  reg [3:0] dly = 4'h0;
  reg [31:0] rdat = 32'h0000_0000;
  reg [31:0] seed = 32'h0000_a6d7;
  reg [7:0] b;
  reg [7:0] dg [0:7];
  reg [38:0] ew [0:1];
  integer failures = 0;
  integer num_checks = 0;
  integer reqs = 0;
  integer oes = 0;
  integer bt, k, i, n, e;
  wire host_tx, line_o, oe, rd_req, wr_valid;
  wire [6:0] rd_addr, wr_addr;
  wire [31:0] wr_data;
  wire [7:0] cnt;
  wire [7:0] node = {6'h00, s1, s0};
  wire line = oe ? line_o : host_tx;
  swurc_top DUT (
    .CLK_I(clk), .RSTN_I(rstn), .SHARED_SERIAL_LINE_I(line),
    .SHARED_SERIAL_LINE_O(line_o), .SHARED_SERIAL_LINE_OE_O(oe),
    .ADDR_SELECT_BIT0_I(s0), .ADDR_SELECT_BIT1_I(s1), .REPLY_DELAY_SETTING_I(dly),
    .RD_REQ_O(rd_req), .RD_ADDR_O(rd_addr), .RD_DATA_I(rdat),
    .WR_VALID_O(wr_valid), .WR_ADDR_O(wr_addr), .WR_DATA_O(wr_data),
    .WR_READY_I(wrdy), .DGRAM_CNT_O(cnt)
  );
  swurc_host host (.clk_i(clk), .line_i(line), .tx_o(host_tx));
  always #20 clk = ~clk;
  // count read strobes and driver turn-ons
  always @(negedge clk)
  begin
    oe_q <= oe;
    if (rd_req === 1'b1) reqs <= reqs + 1;
    if (oe === 1'b1 && oe_q !== 1'b1) oes <= oes + 1;
  end
  // xorshift source
  function [31:0] rnd();
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      rnd = seed;
    end
  endfunction
  function [7:0] crc_of(input integer len);
    integer x, y;
    begin
      crc_of = 8'h00;
      for (x = 0; x < len; x = x + 1)
        for (y = 0; y < 8; y = y + 1)
          crc_of = {crc_of[6:0], crc_of[7] ^ crc_of[1] ^ crc_of[0] ^ dg[x][y]};
    end
  endfunction
  task chk(input [63:0] got, input [63:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
        failures = failures + 1;
        $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
      end
    end
  endtask
  // random header and data, fresh baud
  task fill(input rw, input [7:0] nd);
    reg [31:0] r;
    begin
      r = rnd();
      bt = 16 + r[11:8];
      dg[0] = {r[15:12], 4'h5};
      dg[1] = nd;
      dg[2] = {rw, r[6:0]};
      r = rnd();
      {dg[3], dg[4], dg[5], dg[6]} = r;
    end
  endtask
  task send_dg(input integer len, input [7:0] flip);
    begin
      dg[len-1] = crc_of(len - 1) ^ flip;
      @(posedge clk);
      for (i = 0; i < len; i = i + 1) host.send(dg[i], bt);
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // watchdog over the whole run
  initial
  begin
    repeat (80000) @(posedge clk);
    failures = failures + 1;
    tally_and_finish;
  end
  initial
  begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk({line_o, oe, rd_req, wr_valid, cnt}, 12'h800);
    repeat (220) @(posedge clk);
    // three writes into a stalled sink, the third is dropped
    for (k = 0; k < 3; k = k + 1)
    begin
      fill(1'b1, node);
      if (k < 2) ew[k] = {dg[2][6:0], dg[3], dg[4], dg[5], dg[6]};
      send_dg(8, 8'h00);
    end
    repeat (8) @(negedge clk);
    chk(cnt, 8'h02);
    // drain both entries, one handshake each
    for (k = 0; k < 2; k = k + 1)
    begin
      n = 0;
      do
      begin
        @(negedge clk);
        n = n + 1;
      end while (wr_valid !== 1'b1 && n < 50);
      chk({wr_valid, wr_addr, wr_data}, {1'b1, ew[k]});
      @(posedge clk) wrdy <= 1'b1;
      @(posedge clk) wrdy <= 1'b0;
    end
    // corrupted crc, idle recovery, then a write to another node
    fill(1'b1, node);
    send_dg(8, 8'h10);
    repeat (13 * bt) @(posedge clk);
    fill(1'b1, 8'h02);
    send_dg(8, 8'h00);
    repeat (13 * bt) @(posedge clk);
    chk({wr_valid, cnt}, 9'h002);
    // reads at fresh baud, straps and delay; last to the reply address
    for (k = 0; k < 4; k = k + 1)
    begin
      @(posedge clk);
      e = rnd();
      s0 <= e[0];
      s1 <= e[1];
      // longest delay setting once as a corner case
      dly <= (k == 2) ? 4'hf : {2'b00, e[3:2]};
      rdat <= rnd();
      repeat (20) @(posedge clk);
      fill(1'b0, (k == 3) ? 8'hff : node);
      send_dg(4, 8'h00);
      if (k == 3)
      begin
        repeat (40 * bt) @(posedge clk);
        chk({reqs, oes}, 64'h0000_0003_0000_0003);
      end
      else
      begin
        dg[0] = 8'h05;
        dg[1] = 8'hff;
        {dg[3], dg[4], dg[5], dg[6]} = rdat;
        dg[7] = crc_of(7);
        for (i = 0; i < 8; i = i + 1)
        begin
          host.recv(bt, b, ok, n);
          if (i == 0) e = n - 8 * (dly + 1) * bt;
          chk({ok, b}, {1'b1, dg[i]});
        end
        chk(e > -9 && e < 9, 1'b1);
        n = 0;
        while (oe === 1'b1 && n < 10 * bt)
        begin
          @(negedge clk);
          n = n + 1;
        end
        e = n - bt / 2 - 4 * bt;
        chk(e > -6 && e < 6, 1'b1);
        chk({rd_addr, cnt}, {dg[2][6:0], 8'h02});
        chk(reqs, k + 1);
      end
    end
    tally_and_finish;
  end
endmodule
